// ===== interrupt_ctrl_cfg.svh
// Register map, field positions and reset values of the command block
// Contract
// - A one written to a set-command bit makes that source pending.
// - Any write to end-of-service finishes the current interrupt's treatment.
// - The spurious-vector word stores and reads back a full 32-bit value.
// - Normal or fast vector read with nothing pending returns the spurious value.
// - Debug control bit 0 is the read/write protection mode flag.
// - Global line mask set holds both request outputs inactive.
// - A one written to fast-force enable turns fast forcing on; bit 0 absent.
// - A one written to fast-force disable turns it off; bit 0 absent.
// - Fast-force state reads one per forced source; bit 0 reads zero.
// - End-of-service is write-only with no fields; reads give zero.
// - Set-command is write-only; fast source bit 0, shared bit 1, others above.
`ifndef INTERRUPT_CTRL_CFG_SVH
`define INTERRUPT_CTRL_CFG_SVH
`define ADR_PENDING     32'hfffff10c
`define ADR_SET_PENDING 32'hfffff12c
`define ADR_EOS         32'hfffff130
`define ADR_SPURIOUS    32'hfffff134
`define ADR_DEBUG       32'hfffff138
`define ADR_FF_EN       32'hfffff140
`define ADR_FF_DIS      32'hfffff144
`define ADR_FF_STATE    32'hfffff148
`define ADR_NVEC        32'hfffff150
`define ADR_FVEC        32'hfffff154
`define ADR_EVT_STAT    32'hfffff158
`define ADR_EVT_MASK    32'hfffff15c
`define GUARD_BIT       0
`define GMASK_BIT       1
`define FAST_SRC_BIT    0
`define EVT_NSPUR       0
`define EVT_FSPUR       1
`define EVT_EOS         2
`define ZERO32          32'h0000_0000
`define ZERO5           5'h00
`define ZERO3           3'h0
`define FF_IMPL_MASK    32'hffff_fffe
`define SPUR_RESET      32'h0000_0000
`endif

// ===== interrupt_ctrl_pkg.sv
// Types shared by the interrupt command block
`default_nettype none
package interrupt_ctrl_pkg;
	// Bus answer phase of the slave
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_phase_e;

	// Wishbone request as seen by the slave
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} wb_req_s;

	// Whole register state of the block
	typedef struct packed {
		bus_phase_e  phase;
		logic [31:0] rdata;
		logic [31:0] pending;
		logic [31:0] fast_force;
		logic [31:0] spurious;
		logic [31:0] src_prev;
		logic        guard;
		logic        gmask;
		logic        in_service;
		logic [2:0]  evt_stat;
		logic [2:0]  evt_mask;
		logic        nreq_n;
		logic        freq_n;
		logic        irq;
	} state_s;
endpackage : interrupt_ctrl_pkg
`default_nettype wire

// ===== interrupt_ctrl_command_regs.sv
// Command, configuration and status registers of the interrupt controller
`include "interrupt_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module interrupt_ctrl_command_regs
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Interrupt sources, same clock domain, rising edge sets pending
	input  wire logic [31:0] src_i,
	// Processor request lines, active low, and the protection mode flag, active high
	output logic             normal_request_out_n_o,
	output logic             fast_request_out_n_o,
	output logic             debug_guard_mode_o,
	// Block event interrupt
	output logic             irq_o
);

	interrupt_ctrl_pkg::state_s  s_q;
	interrupt_ctrl_pkg::state_s  s_d;
	interrupt_ctrl_pkg::wb_req_s req;

	// Lowest numbered set bit wins
	function automatic logic [5:0] first_set(input logic [31:0] v);
		logic [5:0] r;
		r = {1'b0, `ZERO5};
		for (int i = 31; i >= 0; i--)
		begin
			if (v[i])
				r = {1'b1, 5'(i)};
		end
		return r;
	endfunction : first_set

	// Byte lane mask from the select lines
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = `ZERO32;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				m[b*8 +: 8] = 8'hff;
		end
		return m;
	endfunction : lane_mask

	// Bundle bus signals
	always_comb
	begin
		req.cyc = cyc_i;
		req.stb = stb_i;
		req.we  = we_i;
		req.sel = sel_i;
		req.adr = adr_i;
		req.dat = dat_i;
	end

	logic        take;
	logic        wr_ack;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] fast_sel;
	logic [31:0] fast_cand;
	logic [31:0] norm_cand;
	logic [5:0]  norm_pick;
	logic [5:0]  fast_pick;

	// Request taken in idle, write acts at the ack edge
	assign take   = req.cyc && req.stb
		&& (s_q.phase == interrupt_ctrl_pkg::BUS_IDLE);
	assign wr_ack = req.cyc && req.stb && req.we
		&& (s_q.phase == interrupt_ctrl_pkg::BUS_ACK);
	assign wmask  = lane_mask(req.sel);
	assign wbits  = req.dat & wmask;

	// Fast source always fast; forced sources follow it
	assign fast_sel  = s_q.fast_force
		| (32'h1 << `FAST_SRC_BIT);
	assign fast_cand = s_q.pending & fast_sel;
	assign norm_cand = s_q.pending & ~fast_sel;
	assign norm_pick = first_set(norm_cand);
	assign fast_pick = first_set(fast_cand);

	// Next state of the whole block
	always_comb
	begin
		logic [31:0] clr_pend;
		logic [31:0] set_pend;
		logic [2:0]  evt_new;
		logic [2:0]  evt_clr;
		clr_pend = `ZERO32;
		set_pend = `ZERO32;
		evt_new  = `ZERO3;
		evt_clr  = `ZERO3;
		s_d      = s_q;

		// One-cycle answer, then ack falls
		if (take)
			s_d.phase = interrupt_ctrl_pkg::BUS_ACK;
		else
			s_d.phase = interrupt_ctrl_pkg::BUS_IDLE;

		// Read data and read side effects at take
		if (take && !req.we)
		begin
			case (req.adr)
				`ADR_PENDING:  s_d.rdata = s_q.pending;
				`ADR_SPURIOUS: s_d.rdata = s_q.spurious;
				`ADR_DEBUG:
				begin
					s_d.rdata = `ZERO32;
					s_d.rdata[`GUARD_BIT] = s_q.guard;
					s_d.rdata[`GMASK_BIT] = s_q.gmask;
				end
				`ADR_FF_STATE:
					s_d.rdata = s_q.fast_force & `FF_IMPL_MASK;
				`ADR_NVEC:
				begin
					if (norm_pick[5])
					begin
						s_d.rdata = 32'(norm_pick[4:0]);
						// Debugger reads must not disturb the claim
						if (!s_q.guard)
						begin
							clr_pend[norm_pick[4:0]] = 1'b1;
							s_d.in_service  = 1'b1;
						end
					end
					else
					begin
						s_d.rdata = s_q.spurious;
						evt_new[`EVT_NSPUR] = 1'b1;
					end
				end
				`ADR_FVEC:
				begin
					if (fast_pick[5])
					begin
						s_d.rdata = 32'(fast_pick[4:0]);
						if (!s_q.guard)
							clr_pend[fast_pick[4:0]] = 1'b1;
					end
					else
					begin
						s_d.rdata = s_q.spurious;
						evt_new[`EVT_FSPUR] = 1'b1;
					end
				end
				`ADR_EVT_STAT: s_d.rdata = 32'(s_q.evt_stat);
				`ADR_EVT_MASK: s_d.rdata = 32'(s_q.evt_mask);
				// Write-only words and holes read as zero
				default:       s_d.rdata = `ZERO32;
			endcase
		end
		else if (take)
			s_d.rdata = `ZERO32;

		// Register writes at the ack edge
		if (wr_ack)
		begin
			case (req.adr)
				`ADR_SET_PENDING: set_pend = wbits;
				`ADR_EOS:
				begin
					// Data ignored, the write alone ends service
					s_d.in_service = 1'b0;
					evt_new[`EVT_EOS] = 1'b1;
				end
				`ADR_SPURIOUS:
					s_d.spurious = (s_q.spurious & ~wmask)
						| wbits;
				`ADR_DEBUG:
				begin
					if (req.sel[0])
					begin
						s_d.guard = req.dat[`GUARD_BIT];
						s_d.gmask = req.dat[`GMASK_BIT];
					end
				end
				`ADR_FF_EN:
					s_d.fast_force = s_q.fast_force
						| (wbits & `FF_IMPL_MASK);
				`ADR_FF_DIS:
					s_d.fast_force = s_q.fast_force
						& ~(wbits & `FF_IMPL_MASK);
				`ADR_EVT_STAT: evt_clr = wbits[2:0];
				`ADR_EVT_MASK:
				begin
					if (req.sel[0])
						s_d.evt_mask = req.dat[2:0];
				end
				default: ;
			endcase
		end

		// Source edges and commands set; sets win over clears
		set_pend     = set_pend | (src_i & ~s_q.src_prev);
		s_d.src_prev = src_i;
		s_d.pending  = (s_q.pending & ~clr_pend) | set_pend;
		s_d.evt_stat = (s_q.evt_stat & ~evt_clr) | evt_new;

		// Next mask value, so no request leaks once the mask is set
		s_d.nreq_n = !((|norm_cand) && !s_q.in_service
			&& !s_d.gmask);
		s_d.freq_n = !((|fast_cand) && !s_d.gmask);
		s_d.irq    = |(s_q.evt_stat & s_q.evt_mask);
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q             <= '0;
			s_q.phase       <= interrupt_ctrl_pkg::BUS_IDLE;
			s_q.spurious    <= `SPUR_RESET;
			s_q.nreq_n      <= 1'b1;
			s_q.freq_n      <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// Outputs
	assign dat_o                  = s_q.rdata;
	assign ack_o                  = (s_q.phase
		== interrupt_ctrl_pkg::BUS_ACK) && req.cyc && req.stb;
	assign normal_request_out_n_o = s_q.nreq_n;
	assign fast_request_out_n_o   = s_q.freq_n;
	assign debug_guard_mode_o     = s_q.guard;
	assign irq_o                  = s_q.irq;

	// Helper terms for the checks
	logic rd_take;
	assign rd_take = take && !req.we;

	sequence s_taken;
		req.cyc && req.stb && (s_q.phase == interrupt_ctrl_pkg::BUS_IDLE);
	endsequence
	sequence s_ack_drop;
		ack_o ##1 !ack_o;
	endsequence
	property p_one_cycle_ack;
		@(posedge clk_i) disable iff (rst_i)
		s_taken |=> s_ack_drop;
	endproperty
	a_one_cycle_ack: assert property (p_one_cycle_ack)
		else $error("ack not one cycle after request");
	property p_set_pending;
		@(posedge clk_i) disable iff (rst_i)
		(wr_ack && req.adr == `ADR_SET_PENDING)
		|=> ((s_q.pending & $past(wbits)) == $past(wbits));
	endproperty
	a_set_pending: assert property (p_set_pending)
		else $error("set command did not make source pending");
	property p_end_service;
		@(posedge clk_i) disable iff (rst_i)
		(wr_ack && req.adr == `ADR_EOS)
		|=> (!s_q.in_service && s_q.evt_stat[`EVT_EOS]);
	endproperty
	a_end_service: assert property (p_end_service)
		else $error("end of service write not taken");
	property p_spurious_rb;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && req.adr == `ADR_SPURIOUS)
		|=> (dat_o == $past(s_q.spurious));
	endproperty
	a_spurious_rb: assert property (p_spurious_rb)
		else $error("spurious word read back wrong");
	property p_spurious_vec;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && req.adr == `ADR_NVEC && !norm_pick[5])
		|=> (ack_o && dat_o == s_q.spurious);
	endproperty
	a_spurious_vec: assert property (p_spurious_vec)
		else $error("spurious normal vector not returned");
	property p_guard_rb;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && req.adr == `ADR_DEBUG)
		|=> (dat_o[`GUARD_BIT] == debug_guard_mode_o);
	endproperty
	a_guard_rb: assert property (p_guard_rb)
		else $error("protection mode bit read back wrong");
	property p_gmask;
		@(posedge clk_i) disable iff (rst_i)
		s_q.gmask |-> (normal_request_out_n_o && fast_request_out_n_o);
	endproperty
	a_gmask: assert property (p_gmask)
		else $error("request line active under global mask");
	property p_ff_enable;
		@(posedge clk_i) disable iff (rst_i)
		(wr_ack && req.adr == `ADR_FF_EN)
		|=> ((s_q.fast_force & $past(wbits) & `FF_IMPL_MASK)
			== ($past(wbits) & `FF_IMPL_MASK)) && !s_q.fast_force[0];
	endproperty
	a_ff_enable: assert property (p_ff_enable)
		else $error("fast forcing enable failed");
	property p_ff_disable;
		@(posedge clk_i) disable iff (rst_i)
		(wr_ack && req.adr == `ADR_FF_DIS)
		|=> ((s_q.fast_force & $past(wbits)) == `ZERO32);
	endproperty
	a_ff_disable: assert property (p_ff_disable)
		else $error("fast forcing disable failed");
	property p_ff_state;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && req.adr == `ADR_FF_STATE)
		|=> (dat_o == (s_q.fast_force & `FF_IMPL_MASK));
	endproperty
	a_ff_state: assert property (p_ff_state)
		else $error("fast forcing state read wrong");
	property p_wo_zero;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && (req.adr == `ADR_EOS || req.adr == `ADR_SET_PENDING))
		|=> (dat_o == `ZERO32);
	endproperty
	a_wo_zero: assert property (p_wo_zero)
		else $error("write-only word read nonzero");
	property p_fast_route;
		@(posedge clk_i) disable iff (rst_i)
		(|(s_q.pending & s_q.fast_force) && !s_d.gmask)
		|=> !fast_request_out_n_o;
	endproperty
	a_fast_route: assert property (p_fast_route)
		else $error("forced source not on fast line");
endmodule : interrupt_ctrl_command_regs
`default_nettype wire

// ===== core_line_model.sv
// Processor core side model: watches the two request lines
`timescale 1ns/1ns
`default_nettype none
module core_line_model
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Request lines from the controller, active low
	input  wire logic       normal_n_i,
	input  wire logic       fast_n_i,
	// Counts of newly raised requests
	output logic      [7:0] normal_seen_o,
	output logic      [7:0] fast_seen_o
);
	logic normal_q;
	logic fast_q;

	// Count falling edges only; a line held low is one request
	always_ff @(posedge clk_i)
	begin
		normal_q <= normal_n_i;
		fast_q <= fast_n_i;
		if (rst_i)
		begin
			normal_seen_o <= 8'h00;
			fast_seen_o <= 8'h00;
		end
		else
		begin
			normal_seen_o <= normal_seen_o + 8'(normal_q & ~normal_n_i);
			fast_seen_o <= fast_seen_o + 8'(fast_q & ~fast_n_i);
		end
	end
endmodule : core_line_model
`default_nettype wire

// ===== interrupt_ctrl_command_regs_tb.sv
// Self-checking bench of the interrupt command registers
`include "interrupt_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module interrupt_ctrl_command_regs_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] adr_i = 32'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] src_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        nreq_n;
	logic        freq_n;
	logic        guard;
	logic        irq_o;
	logic [7:0]  n_seen;
	logic [7:0]  f_seen;
	int          error_cnt = 0;
	int          checks = 0;
	int          cycles = 0;

	interrupt_ctrl_command_regs interrupt_ctrl_command_regs_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .src_i(src_i),
		.normal_request_out_n_o(nreq_n), .fast_request_out_n_o(freq_n),
		.debug_guard_mode_o(guard), .irq_o(irq_o));

	core_line_model core_line_model_inst (
		.clk_i(clk_i), .rst_i(rst_i), .normal_n_i(nreq_n),
		.fast_n_i(freq_n), .normal_seen_o(n_seen), .fast_seen_o(f_seen));

	// 25 MHz clock
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end

	// Hang guard; the full run needs well under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Classic cycle; request held until ack is sampled high
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hf;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input string nm, input logic [31:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rdchk

	// Lets registered outputs settle; ends mid-cycle to sample safely
	task automatic idle();
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask : idle

	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("spurious rst", `ADR_SPURIOUS, `SPUR_RESET);
		rdchk("debug rst", `ADR_DEBUG, 32'h0);
		rdchk("ff rst", `ADR_FF_STATE, 32'h0);
		wr(`ADR_EOS, 32'hffffffff);
		rdchk("eos read", `ADR_EOS, 32'h0);
		rdchk("unmapped", 32'hfffff200, 32'h0);
		rdchk("evt eos", `ADR_EVT_STAT, 32'h4);
		wr(`ADR_EVT_STAT, 32'h7);
		wr(`ADR_SPURIOUS, 32'ha5c31e96);
		rdchk("spurious", `ADR_SPURIOUS, 32'ha5c31e96);
		wr(`ADR_EVT_MASK, 32'h3);
		rdchk("nvec spur", `ADR_NVEC, 32'ha5c31e96);
		rdchk("fvec spur", `ADR_FVEC, 32'ha5c31e96);
		rdchk("evt spur", `ADR_EVT_STAT, 32'h3);
		idle();
		chk("irq on", 32'h1, {31'h0, irq_o});
		wr(`ADR_EVT_MASK, 32'h0);
		idle();
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(`ADR_EVT_STAT, 32'h7);
		// Forced pending source on the normal line
		wr(`ADR_SET_PENDING, 32'h20);
		idle();
		chk("nreq set", 32'h0, {31'h0, nreq_n});
		chk("freq set", 32'h1, {31'h0, freq_n});
		// Protection mode: vector read must not claim
		wr(`ADR_DEBUG, 32'h1);
		rdchk("debug", `ADR_DEBUG, 32'h1);
		chk("guard out", 32'h1, {31'h0, guard});
		rdchk("nvec guard", `ADR_NVEC, 32'h5);
		rdchk("pend guard", `ADR_PENDING, 32'h20);
		wr(`ADR_DEBUG, 32'h0);
		rdchk("nvec", `ADR_NVEC, 32'h5);
		rdchk("pend claimed", `ADR_PENDING, 32'h0);
		idle();
		chk("nreq served", 32'h1, {31'h0, nreq_n});
		wr(`ADR_EOS, 32'h0);
		// Fast forcing enable, disable and status
		wr(`ADR_FF_EN, 32'hffffffff);
		rdchk("ff all", `ADR_FF_STATE, 32'hfffffffe);
		wr(`ADR_FF_DIS, 32'h0000ff01);
		rdchk("ff part", `ADR_FF_STATE, 32'hffff00fe);
		wr(`ADR_FF_DIS, 32'hfffffff7);
		wr(`ADR_SET_PENDING, 32'h8);
		idle();
		chk("freq forced", 32'h0, {31'h0, freq_n});
		chk("nreq forced", 32'h1, {31'h0, nreq_n});
		// Global mask holds both lines while a normal source rises
		wr(`ADR_DEBUG, 32'h2);
		src_i <= 32'h200;
		@(negedge clk_i);
		chk("freq gmask now", 32'h1, {31'h0, freq_n});
		idle();
		chk("freq gmask", 32'h1, {31'h0, freq_n});
		chk("nreq gmask", 32'h1, {31'h0, nreq_n});
		wr(`ADR_DEBUG, 32'h0);
		idle();
		chk("freq back", 32'h0, {31'h0, freq_n});
		chk("nreq back", 32'h0, {31'h0, nreq_n});
		// Fast read claims the forced source, the normal one stays
		rdchk("fvec", `ADR_FVEC, 32'h3);
		rdchk("pend fast", `ADR_PENDING, 32'h200);
		chk("core normal", 32'h2, {24'h0, n_seen});
		chk("core fast", 32'h2, {24'h0, f_seen});
		conclude();
	end
endmodule : interrupt_ctrl_command_regs_tb
`default_nettype wire
